/* File: verilog/adcacw_ctrl.sv */
`timescale 1ns/100ps
// Summary of operation
// - flush bit 1 empties sample fifo and pulses a reset toward the receiver
// - channel enable 1 includes channel in fifo, 0 excludes; all default 1
// - external clock select 1 picks external clock, 0 divided reference; default 0
// - internal sync select 1 makes internal sync pulse, 0 uses sync input
// - polarity 1 active high or rising edge, 0 active low or falling
// - internal trigger select 1 routes internal trigger, 0 external; default external
// - software trigger level bit drives internal trigger, default 1
// - burst code 0 gives 256 samples, doubling per step up to 8M
// - burst code from bits 16,31,30,29; only used in burst capture
// - burst capture with external trigger starts on a trigger edge
// - continuous capture gates samples while trigger at active level
// - sync pulse makes all converters sample and update together
// - on-board clock is 18.8 MHz over divider plus one; default 15
// - burst plus internal trigger: each new control word received while idle starts one burst; a word received mid-burst ends it
// - internal sync at bit 23: one high sync pulse per received word
// - polarity at bit 26: 1 rising, 0 falling for external burst trigger
module adcacw_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  port_data,
  input  wire logic        port_strobe,
  input  wire logic        ref_tick,
  input  wire logic        ext_clk_in,
  input  wire logic        sync_input,
  input  wire logic        trigger_jumper_pin,
  input  wire logic        sample_valid,
  output logic             adc_clk,
  output logic             adc_sync,
  output logic             fifo_flush,
  output logic             rx_reset,
  output logic [7:0]       channel_enable_bits,
  output logic             capture_gate,
  output logic             burst_start,
  output logic [2:0]       indicator_lamp_n,
  output logic [1:0]       adc_mode,
  output logic             adc_half_power
);
  typedef enum logic [2:0] {
    ADCACW_IDLE  = 3'b001,
    ADCACW_BURST = 3'b010,
    ADCACW_CONT  = 3'b100
  } adcacw_state_type;

  localparam int W = adcacw_pkg::WORD_W;

  // assemble burst length code from its scattered bits
  function automatic logic [adcacw_pkg::BLEN_W-1:0] burst_code(input logic [W-1:0] w);
    burst_code = {w[adcacw_pkg::BLEN_HI_BIT], w[adcacw_pkg::BLEN_LO_LSB +: adcacw_pkg::BLEN_W-1]};
  endfunction

  // synchronisers: first stage read only by second
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic       ext_clk_s;
  logic       sync_s;
  logic       trig_s;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {trigger_jumper_pin, sync_input, ext_clk_in};
      s2_q <= s1_q;
    end
  end
  assign ext_clk_s = s2_q[0];
  assign sync_s    = s2_q[1];
  assign trig_s    = s2_q[2];

  // byte assembly, low byte first; word committed only when the 4th byte lands
  logic [W-1:0] shift_q;
  logic [W-1:0] shift_d;
  logic [1:0]   bcnt_q;
  logic [1:0]   bcnt_d;
  logic [W-1:0] ctrl_q;
  logic [W-1:0] ctrl_d;
  logic         new_q;
  logic         new_d;
  always_comb begin
    shift_d = shift_q;
    bcnt_d  = bcnt_q;
    ctrl_d  = ctrl_q;
    new_d   = 1'b0;
    if (port_strobe) begin
      shift_d = {port_data, shift_q[W-1:adcacw_pkg::BYTE_W]};
      bcnt_d  = bcnt_q + 2'h1;
      if (bcnt_q == 2'h3) begin
        ctrl_d = {port_data, shift_q[W-1:adcacw_pkg::BYTE_W]} & adcacw_pkg::CTRL_USED;
        new_d  = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_q <= '0;
      bcnt_q  <= '0;
      ctrl_q  <= adcacw_pkg::CTRL_RESET;
      new_q   <= 1'b0;
    end else begin
      shift_q <= shift_d;
      bcnt_q  <= bcnt_d;
      ctrl_q  <= ctrl_d;
      new_q   <= new_d;
    end
  end

  logic cont_mode;
  logic pol;
  logic int_trig_sel;
  logic trig_raw;
  logic trig_act;
  assign cont_mode    = ctrl_q[adcacw_pkg::CONT_BIT];
  assign pol          = ctrl_q[adcacw_pkg::POL_BIT];
  assign int_trig_sel = ctrl_q[adcacw_pkg::ITRIG_BIT];
  // far end must match trigger type to mode; and
  assign trig_raw = int_trig_sel ? ctrl_q[adcacw_pkg::SWTRIG_BIT] : trig_s;
  assign trig_act = pol ? trig_raw : ~trig_raw;

  // on-board divided clock vs external clock
  logic div_clk;
  adcacw_sample_clock_divide_value #(
    .DIV_W(adcacw_pkg::DIV_W)
  ) u_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .ref_tick  (ref_tick),
    .div_value (ctrl_q[adcacw_pkg::DIV_LSB +: adcacw_pkg::DIV_W]),
    .clk_out   (div_clk)
  );

  // capture state machine
  adcacw_state_type st_q;
  adcacw_state_type st_d;
  logic [adcacw_pkg::CNT_W-1:0] left_q;
  logic [adcacw_pkg::CNT_W-1:0] left_d;
  logic trig_prev_q;
  logic start_d;
  logic [adcacw_pkg::CNT_W-1:0] burst_len;
  assign burst_len = adcacw_pkg::CNT_W'(1) << (burst_code(ctrl_q) + adcacw_pkg::BURST_BASE_LG);

  always_comb begin
    st_d    = st_q;
    left_d  = left_q;
    start_d = 1'b0;
    case (st_q)
      ADCACW_IDLE: begin
        if (cont_mode) begin
          st_d = ADCACW_CONT;
        end else if ((int_trig_sel && new_q) || (!int_trig_sel && trig_act && !trig_prev_q)) begin
          st_d    = ADCACW_BURST;
          left_d  = burst_len;
          start_d = 1'b1;
        end
      end
      ADCACW_BURST: begin
        if (cont_mode || new_q) begin
          st_d = ADCACW_IDLE;
        end else if (sample_valid) begin
          left_d = left_q - adcacw_pkg::CNT_W'(1);
          if (left_q == adcacw_pkg::CNT_W'(1)) begin
            st_d = ADCACW_IDLE;
          end
        end
      end
      ADCACW_CONT: begin
        if (!cont_mode) begin
          st_d = ADCACW_IDLE;
        end
      end
      default: st_d = ADCACW_IDLE;
    endcase
  end

  // outputs, all registered
  logic [2:0] sync_cnt_q;
  logic [2:0] sync_cnt_d;
  logic       sync_d;
  logic       gate_d;
  always_comb begin
    sync_cnt_d = sync_cnt_q;
    if (new_q && ctrl_q[adcacw_pkg::ISYNC_BIT]) begin
      sync_cnt_d = 3'(adcacw_pkg::SYNC_CYCLES);
    end else if (sync_cnt_q != 3'h0) begin
      sync_cnt_d = sync_cnt_q - 3'h1;
    end
    // one pulse aligns all converters
    sync_d = ctrl_q[adcacw_pkg::ISYNC_BIT] ? (sync_cnt_q != 3'h0) : sync_s;
    gate_d = (st_q == ADCACW_CONT) ? trig_act : (st_q == ADCACW_BURST);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q                <= ADCACW_IDLE;
      left_q              <= '0;
      trig_prev_q         <= 1'b1;
      sync_cnt_q          <= '0;
      adc_clk             <= 1'b0;
      adc_sync            <= 1'b0;
      fifo_flush          <= 1'b0;
      rx_reset            <= 1'b0;
      channel_enable_bits <= 8'hFF;
      capture_gate        <= 1'b0;
      burst_start         <= 1'b0;
      indicator_lamp_n    <= 3'h5;
      adc_mode            <= 2'h0;
      adc_half_power      <= 1'b0;
    end else begin
      st_q                <= st_d;
      left_q              <= left_d;
      trig_prev_q         <= trig_act;
      sync_cnt_q          <= sync_cnt_d;
      adc_clk             <= ctrl_q[adcacw_pkg::EXTCLK_BIT] ? ext_clk_s : div_clk;
      adc_sync            <= sync_d;
      fifo_flush          <= new_q & ctrl_q[adcacw_pkg::FLUSH_BIT];
      rx_reset            <= new_q & ctrl_q[adcacw_pkg::FLUSH_BIT];
      channel_enable_bits <= ctrl_q[adcacw_pkg::CHAN_LSB +: adcacw_pkg::CHAN_W];
      capture_gate        <= gate_d;
      burst_start         <= start_d;
      indicator_lamp_n    <= ctrl_q[adcacw_pkg::LAMP_LSB +: adcacw_pkg::LAMP_W];
      adc_mode            <= ctrl_q[adcacw_pkg::MODE_LSB +: adcacw_pkg::MODE_W];
      adc_half_power      <= ctrl_q[adcacw_pkg::HALFPWR_BIT];
    end
  end

  a_flush_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    new_q && ctrl_q[adcacw_pkg::FLUSH_BIT] |=> fifo_flush && rx_reset) else $error("flush missing");
  a_chan_follow: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 channel_enable_bits == $past(ctrl_q[15:8])) else $error("channel enables wrong");
  a_int_burst: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ADCACW_IDLE && !cont_mode && int_trig_sel && new_q |=> st_q == ADCACW_BURST && burst_start)
    else $error("burst not started");
  a_sync_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    new_q && ctrl_q[adcacw_pkg::ISYNC_BIT] ##1 ctrl_q[adcacw_pkg::ISYNC_BIT] |=> adc_sync)
    else $error("no sync pulse");
  a_cont_gate: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ADCACW_CONT |=> capture_gate == $past(trig_act)) else $error("gate mismatch");
  a_burst_len: assert property (@(posedge clk) disable iff (!rst_n)
    start_d |=> left_q == $past(burst_len)) else $error("burst length wrong");
  a_lamp_map: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 indicator_lamp_n == $past(ctrl_q[19:17])) else $error("lamp mismatch");
  a_word_atomic: assert property (@(posedge clk) disable iff (!rst_n)
    !(port_strobe && bcnt_q == 2'h3) |=> $stable(ctrl_q)) else $error("word changed early");
endmodule

/* File: pkg/adcacw_pkg.sv */
package adcacw_pkg;
  localparam int          WORD_W        = 32;
  localparam int          BYTE_W        = 8;
  // control word field positions
  localparam int          DIV_LSB       = 0;
  localparam int          DIV_W         = 4;
  localparam int          FLUSH_BIT     = 7;
  localparam int          CHAN_LSB      = 8;
  localparam int          CHAN_W        = 8;
  localparam int          LAMP_LSB      = 17;
  localparam int          LAMP_W        = 3;
  localparam int          EXTCLK_BIT    = 20;
  localparam int          MODE_LSB      = 21;
  localparam int          MODE_W        = 2;
  localparam int          ISYNC_BIT     = 23;
  localparam int          HALFPWR_BIT   = 24;
  localparam int          CONT_BIT      = 25;
  localparam int          POL_BIT       = 26;
  localparam int          ITRIG_BIT     = 27;
  localparam int          SWTRIG_BIT    = 28;
  localparam int          BLEN_LO_LSB   = 29;
  localparam int          BLEN_HI_BIT   = 16;
  localparam int          BLEN_W        = 4;
  // power-up value: div 15, all channels on, lamps 101, sw trigger 1
  localparam logic [31:0] CTRL_RESET    = 32'h100AFF0F;
  localparam logic [31:0] CTRL_USED     = 32'hFFFFFF8F;
  // clocking
  localparam int          REF_KHZ       = 37600;
  localparam int          BASE_DIV      = 2;
  localparam int          BURST_BASE_LG = 8;
  localparam int          CNT_W         = 24;
  localparam int          SYNC_CYCLES   = 4;
endpackage

/* File: verilog/adcacw_sample_clock_divide_value.sv */
`timescale 1ns/100ps
// divides the reference tick by BASE_DIV*(div+1) and produces a toggling sample clock enable level
module adcacw_sample_clock_divide_value #(
  parameter int DIV_W = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ref_tick,
  input  wire logic [DIV_W-1:0] div_value,
  output logic                  clk_out
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic             out_q;
  logic             out_d;

  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (ref_tick) begin
      if (cnt_q >= div_value) begin
        cnt_d = '0;
        out_d = ~out_q;
      end else begin
        cnt_d = cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign clk_out = out_q;
endmodule

/* File: tb/adcacw_host_model.sv */
`timescale 1ns/100ps
module adcacw_host_model (
  input  wire logic clk,
  output logic [7:0] port_data,
  output logic       port_strobe,
  output logic       trigger_jumper_pin
);
  initial begin
    port_data          = 8'h00;
    port_strobe        = 1'b0;
    trigger_jumper_pin = 1'b0;
  end
  // bytes back to back, low byte first; idle bus shows the inverse so stale data never looks valid
  task automatic send_word(input logic [31:0] w);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1;
      port_strobe = 1'b1;
      port_data   = w[8*i +: 8];
    end
    @(posedge clk);
    #1;
    port_strobe = 1'b0;
    port_data   = ~w[31:24];
  endtask
  // level for continuous capture, a single edge for burst capture
  task automatic set_trigger(input logic lvl);
    @(posedge clk);
    #1;
    trigger_jumper_pin = lvl;
  endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [31:0] w;
    logic [7:0]  chan;
    logic [2:0]  lamp;
    logic [1:0]  mode;
    logic        half;
    logic [1:0]  flush;
    logic [1:0]  sync;
    logic [1:0]  burst;
  } adcacw_row_type;
  localparam adcacw_row_type ROWS [5] = '{
    '{32'h00000000, 8'h00, 3'h0, 2'h0, 1'b0, 2'h0, 2'h0, 2'h0},
    '{32'h01E0C380, 8'hC3, 3'h0, 2'h3, 1'b1, 2'h1, 2'h1, 2'h0},
    '{32'h000E5A0F, 8'h5A, 3'h7, 2'h0, 1'b0, 2'h0, 2'h0, 2'h0},
    '{32'h00000070, 8'h00, 3'h0, 2'h0, 1'b0, 2'h0, 2'h0, 2'h0},
    '{32'h08000000, 8'h00, 3'h0, 2'h0, 1'b0, 2'h0, 2'h0, 2'h1}};
  logic       clk, rst_n, ref_tick, ext_clk_in, sync_input, sample_valid;
  logic [7:0] port_data;
  logic       port_strobe, trigger_jumper_pin;
  logic       adc_clk, adc_sync, fifo_flush, rx_reset, capture_gate, burst_start, adc_half_power;
  logic [7:0] channel_enable_bits;
  logic [2:0] indicator_lamp_n;
  logic [1:0] adc_mode;
  logic       sync_prev, clk_prev;
  int         miscompares, compares, n_flush, n_rx, n_sync, n_burst, n_tog, tick_cnt;

  adcacw_host_model host_u (.clk(clk), .port_data(port_data), .port_strobe(port_strobe),
    .trigger_jumper_pin(trigger_jumper_pin));
  adcacw_ctrl dut_u (.clk(clk), .rst_n(rst_n), .port_data(port_data), .port_strobe(port_strobe),
    .ref_tick(ref_tick), .ext_clk_in(ext_clk_in), .sync_input(sync_input),
    .trigger_jumper_pin(trigger_jumper_pin), .sample_valid(sample_valid), .adc_clk(adc_clk),
    .adc_sync(adc_sync), .fifo_flush(fifo_flush), .rx_reset(rx_reset),
    .channel_enable_bits(channel_enable_bits), .capture_gate(capture_gate), .burst_start(burst_start),
    .indicator_lamp_n(indicator_lamp_n), .adc_mode(adc_mode), .adc_half_power(adc_half_power));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // reference tick once every 7 cycles, close to the on-board oscillator rate
  always @(posedge clk) begin
    tick_cnt <= (tick_cnt == 6) ? 0 : tick_cnt + 1;
    ref_tick <= #1 (tick_cnt == 0);
  end
  always @(posedge clk) begin
    sync_prev <= adc_sync;
    clk_prev  <= adc_clk;
    if (fifo_flush === 1'b1) n_flush++;
    if (rx_reset === 1'b1) n_rx++;
    if (burst_start === 1'b1) n_burst++;
    if (adc_sync === 1'b1 && sync_prev !== 1'b1) n_sync++;
    if (adc_clk !== clk_prev) n_tog++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (12) @(posedge clk);
    #1;
  endtask
  task automatic word(input logic [31:0] w);
    n_flush = 0; n_rx = 0; n_sync = 0; n_burst = 0;
    host_u.send_word(w);
    settle();
  endtask
  task automatic do_reset();
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    check(indicator_lamp_n, 3'h5);
    check(channel_enable_bits, 8'hFF);
    check({adc_half_power, adc_mode}, 3'h0);
    rst_n = 1'b1;
  endtask
  task automatic report_and_stop();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #40000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    {rst_n, ref_tick, ext_clk_in, sync_input, sample_valid, tick_cnt} = '0;
    {miscompares, compares, n_tog} = '0;
    do_reset();
    foreach (ROWS[i]) begin
      word(ROWS[i].w);
      check(channel_enable_bits, ROWS[i].chan);
      check(indicator_lamp_n, ROWS[i].lamp);
      check({adc_half_power, adc_mode}, {ROWS[i].half, ROWS[i].mode});
      check(n_flush, ROWS[i].flush);
      check(n_rx, ROWS[i].flush);
      check(n_sync, ROWS[i].sync);
      check(n_burst, ROWS[i].burst);
    end
    // continuous capture, active high trigger level
    word(32'h06000000);
    check(capture_gate, 1'b0);
    host_u.set_trigger(1'b1);
    settle();
    check(capture_gate, 1'b1);
    host_u.set_trigger(1'b0);
    settle();
    check(capture_gate, 1'b0);
    // burst on rising edge only; the falling edge must not restart it
    word(32'h04000000);
    host_u.set_trigger(1'b1);
    settle();
    check(n_burst, 1);
    host_u.set_trigger(1'b0);
    settle();
    check(n_burst, 1);
    // pin raised first so the polarity change itself makes no edge
    host_u.set_trigger(1'b1);
    word(32'h00000000);
    host_u.set_trigger(1'b0);
    settle();
    check(n_burst, 1);
    word(32'h1E000000);
    check(capture_gate, 1'b1);
    word(32'h0E000000);
    check(capture_gate, 1'b0);
    word(32'h00100000);
    ext_clk_in = 1'b1;
    settle();
    check(adc_clk, 1'b1);
    ext_clk_in = 1'b0;
    settle();
    check(adc_clk, 1'b0);
    // divider 1: one toggle per two ticks, 140 cycles give ten, phase may shift one
    word(32'h00000001);
    n_tog = 0;
    repeat (140) @(posedge clk);
    #1;
    check(n_tog >= 9 && n_tog <= 11, 1);
    // external sync passes through when internal sync is off
    word(32'h00000000);
    sync_input = 1'b1;
    settle();
    check(adc_sync, 1'b1);
    sync_input = 1'b0;
    settle();
    check(adc_sync, 1'b0);
    // internal burst of 256 samples ends after the 256th counted sample
    word(32'h08000000);
    check(capture_gate, 1'b1);
    sample_valid = 1'b1;
    repeat (255) @(posedge clk);
    #1;
    check(capture_gate, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    sample_valid = 1'b0;
    check(capture_gate, 1'b0);
    do_reset();
    report_and_stop();
  end
endmodule
